// *** core/lds_defs.svh ***
// Register map, field positions, reset values and timing for the sequencer
`ifndef LDS_DEFS_SVH
`define LDS_DEFS_SVH

`define LDS_CLK_MHZ 250
`define LDS_RELEVEL_MS 16'd1000

`define LDS_ADDR_CFG 8'h00
`define LDS_ADDR_TIME 8'h04
`define LDS_ADDR_CMD 8'h08
`define LDS_ADDR_STAT 8'h0c

`define LDS_CFG_TYPE_LSB 0
`define LDS_CFG_OT_LSB 2
`define LDS_CFG_VB_LSB 5
`define LDS_CFG_VFD_LSB 7
`define LDS_CFG_FIRST_LSB 11
`define LDS_CFG_TRIG_BIT 14
`define LDS_CFG_RST 32'h0000_0000

`define LDS_TIME_OT_LSB 0
`define LDS_TIME_BRK_LSB 16
`define LDS_TIME_RST 32'h0064_00c8

`define LDS_CMD_UP_BIT 0
`define LDS_CMD_DN_BIT 1
`define LDS_CMD_SPD_LSB 2
`define LDS_CMD_INSP_BIT 5
`define LDS_CMD_RELEV_BIT 6
`define LDS_CMD_ABORT_BIT 7

`define LDS_TYPE_MAX 2'h2
`define LDS_VFD_MAX 4'h8
`define LDS_SPD_SLOW 3'h1
`define LDS_SPD_MED 3'h2

`endif

// *** core/lds_ms_timer.sv ***
// Loadable millisecond down-counter with a cycle prescaler
`timescale 1ns/1ps
module lds_ms_timer #(
    parameter int CYC_PER_MS = 250000,
    parameter int MS_W = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [MS_W-1:0] load_ms,
    output logic busy,
    output logic done
);
    localparam int PW = $clog2(CYC_PER_MS) + 1;
    localparam logic [PW-1:0] PRE_TOP = PW'(CYC_PER_MS - 1);

    logic [MS_W-1:0] ms_ff;
    logic [PW-1:0] pre_ff;
    logic busy_ff;
    logic done_ff;

    // A load while running restarts the count from the new value
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ms_ff <= '0;
            pre_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (load) begin
                ms_ff <= load_ms;
                pre_ff <= PRE_TOP;
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                if (ms_ff == '0) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end else if (pre_ff == '0) begin
                    ms_ff <= ms_ff - 1'b1;
                    pre_ff <= PRE_TOP;
                end else begin
                    pre_ff <= pre_ff - 1'b1;
                end
            end
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;
endmodule : lds_ms_timer

// *** core/lds_pkg.sv ***
// Types shared by the drive stop sequencer
package lds_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_BRAKE,
        ST_OVER,
        ST_HOLD
    } lds_state_t;

    typedef enum logic [1:0] {
        LT_ROPE2,
        LT_HYDRO,
        LT_VFD
    } lds_lift_t;

    typedef enum logic [2:0] {
        OT_NONE,
        OT_VALVE,
        OT_MOTOR,
        OT_ELRV,
        OT_VFDHYD
    } lds_ot_t;
endpackage : lds_pkg

// *** core/lds_sequencer.sv ***
// Lift drive stop sequencer with AHB-Lite register access
`timescale 1ns/1ps
`include "lds_defs.svh"
module lds_sequencer #(
    parameter int CYC_PER_MS = `LDS_CLK_MHZ * 1000
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic centre_zone_switch,
    input wire logic upper_zone_switch,
    input wire logic lower_zone_switch,
    input wire logic car_standstill,
    output logic up_direction_relay,
    output logic down_direction_relay,
    output logic pump_motor,
    output logic star_delta_relay,
    output logic up_valve,
    output logic down_valve,
    output logic valve_electronics,
    output logic [15:0] speed_group,
    output logic second_zone_signal
);
    lds_pkg::lds_state_t state_ff;
    logic [31:0] cfg_ff, time_ff, hrdata_ff;
    logic [7:0] addr_ff;
    logic wr_ff, dph_ff, hreadyout_ff, hresp_ff;
    logic [3:0] sync1_ff, sync2_ff, prev_ff;
    logic dir_up_ff;
    logic [2:0] spd_ff;
    logic [15:0] group_ff, nxt_group;
    logic up_rel_ff, dn_rel_ff, pump_ff, sd_ff, upv_ff, dnv_ff, vel_ff;
    logic zone2_ff;
    logic ot_busy, ot_done, brk_busy, brk_done, rlv_busy;

    // Register fields and decoded settings
    wire logic [1:0] lift_type = cfg_ff[`LDS_CFG_TYPE_LSB +: 2];
    wire logic [2:0] ot_mode = cfg_ff[`LDS_CFG_OT_LSB +: 3];
    wire logic [1:0] vb_mode = cfg_ff[`LDS_CFG_VB_LSB +: 2];
    wire logic [3:0] vfd_sel = cfg_ff[`LDS_CFG_VFD_LSB +: 4];
    wire logic [2:0] vfd_first = cfg_ff[`LDS_CFG_FIRST_LSB +: 3];
    wire logic stop_trig = cfg_ff[`LDS_CFG_TRIG_BIT];
    wire logic hyd = (lift_type == lds_pkg::LT_HYDRO);
    wire logic vfd_binary = (vfd_sel == 4'h2) || (vfd_sel == 4'h4) ||
        (vfd_sel == 4'h6) || (vfd_sel == 4'h7) || (vfd_sel == 4'h8);

    // AHB-Lite slave, zero wait states, always OKAY
    wire logic acc = hsel && hready && htrans[1];
    wire logic wr_en = dph_ff && wr_ff;
    wire logic cmd_go = wr_en && (addr_ff == `LDS_ADDR_CMD);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            dph_ff <= 1'b0;
            wr_ff <= 1'b0;
            addr_ff <= 8'h00;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end else begin
            dph_ff <= acc;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
            if (acc) begin
                addr_ff <= haddr[7:0];
                wr_ff <= hwrite;
            end
        end
    end

    // Out-of-range lift type and VFD selections are dropped so the drive never sees them
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cfg_ff <= `LDS_CFG_RST;
            time_ff <= `LDS_TIME_RST;
        end else if (wr_en && addr_ff == `LDS_ADDR_CFG) begin
            cfg_ff[14:2] <= hwdata[14:2];
            if (hwdata[`LDS_CFG_TYPE_LSB +: 2] <= `LDS_TYPE_MAX) begin
                cfg_ff[`LDS_CFG_TYPE_LSB +: 2] <=
                    hwdata[`LDS_CFG_TYPE_LSB +: 2];
            end
            if (hwdata[`LDS_CFG_VFD_LSB +: 4] > `LDS_VFD_MAX) begin
                cfg_ff[`LDS_CFG_VFD_LSB +: 4] <= vfd_sel;
            end
        end else if (wr_en && addr_ff == `LDS_ADDR_TIME) begin
            time_ff <= hwdata;
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            `LDS_ADDR_CFG: rd_mux = cfg_ff;
            `LDS_ADDR_TIME: rd_mux = time_ff;
            `LDS_ADDR_STAT: rd_mux = {group_ff, 1'b0, rlv_busy, zone2_ff,
                sync2_ff[2:0], vel_ff, dnv_ff, upv_ff, sd_ff, pump_ff,
                dn_rel_ff, up_rel_ff, state_ff};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is latched in the address phase, valid in the data phase
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata_ff <= rd_mux;
        end
    end

    // Pins: centre, upper, lower, standstill through two flip-flops
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            prev_ff <= 4'h0;
        end else begin
            sync1_ff <= {car_standstill, lower_zone_switch,
                upper_zone_switch, centre_zone_switch};
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    wire logic centre_in = sync2_ff[0];
    wire logic standstill = sync2_ff[3];
    wire logic [2:0] rise = sync2_ff[2:0] & ~prev_ff[2:0];
    wire logic outer_rise = dir_up_ff ? rise[2] : rise[1];
    wire logic trig = stop_trig ? rise[0] : outer_rise;

    // Events of the travel sequence
    wire logic req_up = hwdata[`LDS_CMD_UP_BIT];
    wire logic req_dn = hwdata[`LDS_CMD_DN_BIT];
    wire logic relev = hwdata[`LDS_CMD_RELEV_BIT];
    wire logic start_ok = cmd_go && state_ff == lds_pkg::ST_IDLE &&
        (req_up ^ req_dn) &&
        !(relev && hyd && vb_mode == 2'h2 && rlv_busy);
    wire logic moving = state_ff == lds_pkg::ST_RUN ||
        state_ff == lds_pkg::ST_BRAKE;
    wire logic brk_start = state_ff == lds_pkg::ST_RUN && trig;
    wire logic stop_now = moving && ((cmd_go && hwdata[`LDS_CMD_ABORT_BIT])
        || (state_ff == lds_pkg::ST_BRAKE && brk_done)
        || (stop_trig && outer_rise));
    wire logic ot_need = hyd && ((dir_up_ff &&
        (ot_mode == lds_pkg::OT_VALVE || ot_mode == lds_pkg::OT_MOTOR))
        || ot_mode == lds_pkg::OT_ELRV);
    wire logic hold_need = hyd && vb_mode == 2'h1 && dir_up_ff;
    wire logic ot_end = state_ff == lds_pkg::ST_OVER && ot_done;
    wire logic done_evt = (stop_now && !ot_need && !hold_need) ||
        (ot_end && !hold_need) ||
        (state_ff == lds_pkg::ST_HOLD && standstill);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_ff <= lds_pkg::ST_IDLE;
            dir_up_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                lds_pkg::ST_IDLE: begin
                    if (start_ok) begin
                        state_ff <= lds_pkg::ST_RUN;
                        dir_up_ff <= req_up;
                    end
                end
                lds_pkg::ST_RUN, lds_pkg::ST_BRAKE: begin
                    if (stop_now) begin
                        state_ff <= ot_need ? lds_pkg::ST_OVER :
                            hold_need ? lds_pkg::ST_HOLD : lds_pkg::ST_IDLE;
                    end else if (brk_start) begin
                        state_ff <= lds_pkg::ST_BRAKE;
                    end
                end
                lds_pkg::ST_OVER: begin
                    if (ot_done) begin
                        state_ff <= hold_need ? lds_pkg::ST_HOLD :
                            lds_pkg::ST_IDLE;
                    end
                end
                lds_pkg::ST_HOLD: begin
                    if (standstill) begin
                        state_ff <= lds_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    lds_ms_timer #(.CYC_PER_MS(CYC_PER_MS), .MS_W(16)) brk_tmr (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(brk_start),
        .load_ms(time_ff[`LDS_TIME_BRK_LSB +: 16]),
        .busy(brk_busy),
        .done(brk_done)
    );

    lds_ms_timer #(.CYC_PER_MS(CYC_PER_MS), .MS_W(16)) ot_tmr (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(stop_now && ot_need),
        .load_ms(time_ff[`LDS_TIME_OT_LSB +: 16]),
        .busy(ot_busy),
        .done(ot_done)
    );

    lds_ms_timer #(.CYC_PER_MS(CYC_PER_MS), .MS_W(16)) rlv_tmr (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(done_evt && hyd && vb_mode == 2'h2),
        .load_ms(`LDS_RELEVEL_MS),
        .busy(rlv_busy),
        .done()
    );

    // Contactor and valve outputs; stop pattern depends on overtravel mode
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            {up_rel_ff, dn_rel_ff, pump_ff, sd_ff} <= 4'h0;
            {upv_ff, dnv_ff, vel_ff} <= 3'h0;
        end else if (start_ok) begin
            up_rel_ff <= req_up;
            dn_rel_ff <= req_dn;
            if (hyd) begin
                pump_ff <= req_up;
                upv_ff <= req_up;
                vel_ff <= 1'b1;
                sd_ff <= req_up || vb_mode != 2'h0;
                dnv_ff <= req_dn && vb_mode == 2'h0;
            end
        end else if (stop_now) begin
            {up_rel_ff, dn_rel_ff, pump_ff, sd_ff} <= 4'h0;
            {upv_ff, dnv_ff, vel_ff} <= 3'h0;
            if (hyd && dir_up_ff) begin
                unique case (ot_mode)
                    lds_pkg::OT_VALVE: begin
                        upv_ff <= 1'b1;
                        vel_ff <= 1'b1;
                        sd_ff <= 1'b1;
                    end
                    lds_pkg::OT_MOTOR, lds_pkg::OT_ELRV: begin
                        pump_ff <= 1'b1;
                        sd_ff <= 1'b1;
                    end
                    default: begin
                    end
                endcase
                if (vb_mode == 2'h1) begin
                    upv_ff <= 1'b1;
                    vel_ff <= 1'b0;
                end
            end else if (hyd && ot_mode == lds_pkg::OT_ELRV) begin
                dnv_ff <= dnv_ff;
                sd_ff <= sd_ff;
                vel_ff <= vel_ff;
            end
        end else if (ot_end) begin
            {pump_ff, sd_ff, dnv_ff, vel_ff} <= 4'h0;
            upv_ff <= upv_ff && hold_need;
        end else if (state_ff == lds_pkg::ST_HOLD && standstill) begin
            upv_ff <= 1'b0;
        end
    end

    // Requested speed; inspection travel goes medium only on hydraulic lifts with vb_mode nonzero
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            spd_ff <= 3'h0;
        end else if (start_ok) begin
            if (hwdata[`LDS_CMD_INSP_BIT]) begin
                spd_ff <= (hyd && vb_mode != 2'h0) ? `LDS_SPD_MED :
                    `LDS_SPD_SLOW;
            end else begin
                spd_ff <= hwdata[`LDS_CMD_SPD_LSB +: 3];
            end
        end else if (brk_start) begin
            spd_ff <= `LDS_SPD_SLOW;
        end else if (stop_now) begin
            spd_ff <= 3'h0;
        end
    end

    always_comb begin
        nxt_group = 16'h0000;
        if (lift_type == lds_pkg::LT_VFD) begin
            if (vfd_binary) begin
                nxt_group = {13'h0000, spd_ff} << vfd_first;
            end else begin
                nxt_group = (16'(16'h0001 << spd_ff) >> 1) << vfd_first;
            end
            if (vfd_sel == 4'h7 && moving) begin
                nxt_group = nxt_group | (16'h0040 << vfd_first);
            end
        end else if (lift_type == lds_pkg::LT_ROPE2) begin
            nxt_group = {14'h0000, spd_ff == 3'h1, spd_ff > 3'h1};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            group_ff <= 16'h0000;
        end else begin
            group_ff <= nxt_group;
        end
    end

    // Second zone is gated by the centre zone so it can never lead it
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            zone2_ff <= 1'b0;
        end else begin
            zone2_ff <= centre_in && (sync2_ff[1] || sync2_ff[2]);
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign up_direction_relay = up_rel_ff;
    assign down_direction_relay = dn_rel_ff;
    assign pump_motor = pump_ff;
    assign star_delta_relay = sd_ff;
    assign up_valve = upv_ff;
    assign down_valve = dnv_ff;
    assign valve_electronics = vel_ff;
    assign speed_group = group_ff;
    assign second_zone_signal = zone2_ff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    type_range_a: assert property (lift_type <= `LDS_TYPE_MAX)
        else $error("lift type out of range");
    stop_all_a: assert property (stop_now && hyd && ot_mode == 3'h0 &&
        vb_mode == 2'h0 |=> !pump_ff && !upv_ff && !dnv_ff && !sd_ff)
        else $error("overtravel 0 left an output on");
    valve_ot_a: assert property (stop_now && hyd && dir_up_ff &&
        ot_mode == 3'h1 |=> upv_ff && sd_ff && !up_rel_ff && !pump_ff
        ##1 sd_ff [*1])
        else $error("valve overtravel pattern wrong");
    motor_ot_a: assert property (stop_now && hyd && dir_up_ff &&
        ot_mode == 3'h2 && vb_mode == 2'h0 |=> pump_ff && !upv_ff &&
        !vel_ff && $fell(up_rel_ff))
        else $error("motor overtravel pattern wrong");
    pump_end_a: assert property (ot_end |=> !pump_ff && !sd_ff)
        else $error("pump still on after overtravel");
    down_hold_a: assert property (state_ff == lds_pkg::ST_OVER &&
        !dir_up_ff && !ot_done |-> !dn_rel_ff)
        else $error("down direction not dropped");
    delta_down_a: assert property (moving && hyd && !dir_up_ff &&
        vb_mode != 2'h0 |-> sd_ff && !dnv_ff)
        else $error("down valve not on delta contactor");
    relevel_gap_a: assert property (cmd_go && relev && hyd &&
        vb_mode == 2'h2 && rlv_busy |=> state_ff == lds_pkg::ST_IDLE)
        else $error("relevel started inside guard time");
    binary_code_a: assert property (lift_type == lds_pkg::LT_VFD &&
        vfd_binary && $stable(cfg_ff) |=>
        3'(group_ff >> vfd_first) == $past(spd_ff))
        else $error("binary speed code wrong");
    outer_stop_a: assert property (state_ff == lds_pkg::ST_BRAKE &&
        stop_trig && outer_rise |=> !moving)
        else $error("outer switch did not end travel");
    zone_order_a: assert property ($rose(zone2_ff) |->
        $past(centre_in))
        else $error("second zone ahead of centre zone");

    brake_seen_c: cover property (brk_start ##[1:1000] stop_now);
    overtravel_c: cover property (ot_end);
    hold_c: cover property (state_ff == lds_pkg::ST_HOLD && standstill);
endmodule : lds_sequencer

// *** tb/lds_shaft_model.sv ***
// Shaft model: zone switches on arrival, standstill after travel
`timescale 1ns/1ps
module lds_shaft_model #(
    parameter int GAP = 40
) (
    input wire logic sys_clk,
    input wire logic arrive,
    input wire logic up_direction_relay,
    input wire logic down_direction_relay,
    output logic centre_zone_switch,
    output logic upper_zone_switch,
    output logic lower_zone_switch,
    output logic car_standstill
);
    int cnt = 0;
    int still = 0;
    logic going_up = 1'b0;
    logic lead, trail;
    always @(posedge sys_clk) begin
        if (!arrive) begin
            cnt <= 0;
            going_up <= up_direction_relay;
        end else if (cnt < 4 * GAP) begin
            cnt <= cnt + 1;
        end
        // The car slides on for a while after the relays drop
        if (up_direction_relay || down_direction_relay) begin
            still <= 0;
        end else if (still < 15) begin
            still <= still + 1;
        end
    end
    // Leading outer switch, then centre, then trailing outer switch
    assign lead = arrive && cnt >= GAP;
    assign trail = arrive && cnt >= 3 * GAP;
    assign centre_zone_switch = arrive && cnt >= 2 * GAP;
    assign upper_zone_switch = going_up ? lead : trail;
    assign lower_zone_switch = going_up ? trail : lead;
    assign car_standstill = still >= 15;
endmodule : lds_shaft_model

// *** tb/tb_lift_drive_stop_sequencer.sv ***
// Self-checking bench for the drive stop sequencer
`timescale 1ns/1ps
`include "lds_defs.svh"
module tb_lift_drive_stop_sequencer;
    logic sys_clk, reset_n, hsel, hwrite, hreadyout, hresp, arrive;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic centre_zone_switch, upper_zone_switch, lower_zone_switch;
    logic car_standstill, up_direction_relay, down_direction_relay;
    logic pump_motor, star_delta_relay, up_valve, down_valve;
    logic valve_electronics, second_zone_signal;
    logic [15:0] speed_group;
    logic [6:0] outs, prev, mid;
    logic [3:0] zn, zprev;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int ft[7];
    int zr[4];

    assign outs = {up_direction_relay, down_direction_relay, pump_motor,
        star_delta_relay, up_valve, down_valve, valve_electronics};
    assign zn = {second_zone_signal, centre_zone_switch, upper_zone_switch,
        lower_zone_switch};

    lds_sequencer #(.CYC_PER_MS(10)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .centre_zone_switch(centre_zone_switch),
        .upper_zone_switch(upper_zone_switch),
        .lower_zone_switch(lower_zone_switch),
        .car_standstill(car_standstill),
        .up_direction_relay(up_direction_relay),
        .down_direction_relay(down_direction_relay),
        .pump_motor(pump_motor), .star_delta_relay(star_delta_relay),
        .up_valve(up_valve), .down_valve(down_valve),
        .valve_electronics(valve_electronics), .speed_group(speed_group),
        .second_zone_signal(second_zone_signal)
    );

    lds_shaft_model shaft_u (
        .sys_clk(sys_clk), .arrive(arrive),
        .up_direction_relay(up_direction_relay),
        .down_direction_relay(down_direction_relay),
        .centre_zone_switch(centre_zone_switch),
        .upper_zone_switch(upper_zone_switch),
        .lower_zone_switch(lower_zone_switch),
        .car_standstill(car_standstill)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Cycle of the last fall of each output and last rise of each zone
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        prev <= outs;
        zprev <= zn;
        for (int i = 0; i < 7; i++) begin
            if (prev[i] === 1'b1 && outs[i] === 1'b0) ft[i] <= cyc;
        end
        for (int i = 0; i < 4; i++) begin
            if (zprev[i] === 1'b0 && zn[i] === 1'b1) zr[i] <= cyc;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Delays carry a few cycles of pin synchronisation, hence the margin
    task automatic chk_near(input int got, input int exp);
        checks++;
        if (got < exp - 4 || got > exp + 4) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_near

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    function automatic logic [31:0] mkcfg(input int t, ot, vb, sel, tr);
        return 32'((t << `LDS_CFG_TYPE_LSB) | (ot << `LDS_CFG_OT_LSB) |
            (vb << `LDS_CFG_VB_LSB) | (sel << `LDS_CFG_VFD_LSB) |
            (1 << `LDS_CFG_FIRST_LSB) | (tr << `LDS_CFG_TRIG_BIT));
    endfunction : mkcfg

    function automatic logic [31:0] mkcmd(input int up, input int spd);
        return 32'((up != 0 ? 1 << `LDS_CMD_UP_BIT : 1 << `LDS_CMD_DN_BIT)
            | (spd << `LDS_CMD_SPD_LSB));
    endfunction : mkcmd

    task automatic trip(input int ot, vb, tr, up);
        int n;
        bus(1'b1, `LDS_ADDR_CFG, mkcfg(1, ot, vb, 0, tr));
        bus(1'b1, `LDS_ADDR_CMD, mkcmd(up, 1));
        repeat (20) @(posedge sys_clk);
        mid = outs;
        arrive <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((outs !== 7'h0 || n < 200) && n < 3000);
        arrive <= 1'b0;
        chk(32'(outs), 32'h0);
        repeat (4) @(posedge sys_clk);
    endtask : trip

    task automatic t_regs;
        bus(1'b0, `LDS_ADDR_TIME, 32'h0);
        chk(q, `LDS_TIME_RST);
        bus(1'b1, `LDS_ADDR_CFG, 32'h3);
        bus(1'b0, `LDS_ADDR_CFG, 32'h0);
        chk(q, `LDS_CFG_RST);
        bus(1'b1, `LDS_ADDR_CFG, 32'h0000_0780);
        bus(1'b0, `LDS_ADDR_CFG, 32'h0);
        chk(q, `LDS_CFG_RST);
        bus(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, `LDS_ADDR_TIME, 32'h0002_0003);
    endtask : t_regs

    task automatic t_hydro;
        trip(0, 0, 0, 1);
        chk(ft[4], ft[2]);
        chk(ft[0], ft[2]);
        chk_near(ft[6] - zr[0], 25);
        chk_near(zr[3] - zr[2], 4);
        trip(2, 0, 0, 1);
        chk_near(ft[4] - ft[2], 31);
        trip(1, 0, 0, 1);
        chk_near(ft[3] - ft[6], 31);
        chk_near(ft[2] - ft[4], 31);
        trip(3, 0, 0, 1);
        chk_near(ft[4] - ft[6], 31);
        trip(3, 0, 0, 0);
        chk_near(ft[1] - ft[5], 31);
        trip(0, 0, 1, 1);
        chk_near(ft[6] - zr[2], 25);
        // Long brake time: only the trailing outer switch can stop in time
        bus(1'b1, `LDS_ADDR_TIME, 32'h0032_0003);
        trip(0, 0, 1, 0);
        chk_near(ft[5] - zr[1], 4);
        bus(1'b1, `LDS_ADDR_TIME, 32'h0002_0003);
    endtask : t_hydro

    task automatic t_block;
        trip(0, 1, 0, 0);
        chk(32'({mid[3], mid[1]}), 32'h2);
        trip(0, 1, 0, 1);
        chk_near(ft[2] - ft[0], 18);
        trip(0, 2, 0, 1);
        bus(1'b1, `LDS_ADDR_CMD, mkcmd(1, 1) | 32'h40);
        repeat (5) @(posedge sys_clk);
        chk(32'(outs), 32'h0);
        bus(1'b0, `LDS_ADDR_STAT, 32'h0);
        chk(32'(q[14]), 32'h1);
        repeat (10000) @(posedge sys_clk);
        bus(1'b1, `LDS_ADDR_CMD, mkcmd(1, 1) | 32'h40);
        repeat (5) @(posedge sys_clk);
        chk(32'(outs[6]), 32'h1);
        bus(1'b1, `LDS_ADDR_CMD, 32'h80);
        repeat (40) @(posedge sys_clk);
    endtask : t_block

    task automatic t_vfd;
        int sp;
        logic [15:0] e;
        for (int i = 0; i < 11; i++) begin
            sp = (i == 9) ? 1 : 3;
            bus(1'b1, `LDS_ADDR_CFG, mkcfg(i < 9 ? 2 : 0, 0, 0, i % 9, 0));
            bus(1'b1, `LDS_ADDR_CMD, mkcmd(1, sp));
            repeat (5) @(posedge sys_clk);
            e = (i inside {2, 4, 6, 7, 8}) ? 16'h6 : 16'h8;
            if (i == 7) e = e | 16'h80;
            if (i > 8) e = (i == 9) ? 16'h2 : 16'h1;
            chk(32'(speed_group), 32'(e));
            bus(1'b1, `LDS_ADDR_CMD, 32'h80);
            repeat (40) @(posedge sys_clk);
        end
    endtask : t_vfd

    task automatic finish_test;
        if (err_total == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    initial begin
        {reset_n, hsel, hwrite, arrive} = 4'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_regs();
        t_hydro();
        t_block();
        t_vfd();
        finish_test();
    end

    initial begin
        #200us;
        err_total++;
        finish_test();
    end
endmodule : tb_lift_drive_stop_sequencer
